// File: core/lsi_consts.svh
// Constants for the laser safety and indicator controller
`ifndef LSI_CONSTS_SVH
`define LSI_CONSTS_SVH

// Clock rate and timing figures
`define LSI_CLK_HZ 250000000
`define LSI_WARN_S 5
`define LSI_BLINK_HZ 1
`define LSI_SETTLE_CYC 16

// Register byte offsets
`define LSI_OFS_CTRL 12'h000
`define LSI_OFS_STATE 12'h004
`define LSI_OFS_IRQ_STAT 12'h008
`define LSI_OFS_IRQ_MASK 12'h00C

// Reset values
`define LSI_CTRL_RST 16'h0000
`define LSI_MASK_RST 5'h00

// Control field positions
`define LSI_CTRL_EN_LSB 0
`define LSI_CTRL_SHUT_LSB 8

// Interrupt bit positions
`define LSI_IRQ_ALARM 0
`define LSI_IRQ_ILK 1
`define LSI_IRQ_WARN 2
`define LSI_IRQ_EMIT 3
`define LSI_IRQ_BLANK 4
`define LSI_NIRQ 5

`endif

// File: core/lsi_ctrl.sv
// Safety interlock, emission sequencing and panel LEDs
// Operation
// - Green status LED dark while no source is enabled for emission.
// - Green LED steady when all enabled sources emit and are stabilized.
// - Green LED blinks while any enabled source is still stabilizing.
// - Red alarm LED steady on any source alarm or open interlock.
// - Open interlock loop disables emission of every source.
// - No emission while the emission key is absent or off.
// - Key on starts emission only once the unit is ready.
// - White emission LED steady on while the key is switched on.
// - Emission LED blinks five seconds before emission; emission waits for it.
// - Panel shutter switch closed forces every shutter closed.
// - Shutter switch LED lit only while that switch is open.
// - Blanking cuts all source output and lights the blanking LED.
// - Rear blanking socket also blanks all sources at once.
// - Shutter driven by electrical input or software command.
// - Each source output follows its digital modulation input.
// - Independent status and control per source, up to two sources.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lsi_consts.svh"

module lsi_ctrl
  import lsi_pkg::*;
#(
  parameter int unsigned NSRC = 2,
  parameter int unsigned WARN_CYC = `LSI_WARN_S * `LSI_CLK_HZ,
  parameter int unsigned BLINK_HALF_CYC = `LSI_CLK_HZ / (2 * `LSI_BLINK_HZ)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Panel and unit inputs
  input wire lsi_panel_t panel,
  input wire logic unit_ready,
  // Per-source inputs
  input wire logic [NSRC-1:0] src_alarm,
  input wire logic [NSRC-1:0] src_stab,
  input wire logic [NSRC-1:0] mod_in,
  input wire logic [NSRC-1:0] shut_cmd_in,
  // Per-source outputs
  output logic [NSRC-1:0] emit_en,
  output logic [NSRC-1:0] src_out_on,
  output logic [NSRC-1:0] shutter_open,
  // Indicators and interrupt
  output lsi_leds_t leds,
  output logic irq
);

  localparam int unsigned NIN = 6 + 4 * NSRC;

  // State
  lsi_state_t st_reg;
  lsi_state_t st_next;
  logic [31:0] warn_cnt_reg;
  logic [31:0] warn_cnt_next;
  logic [31:0] blink_cnt_reg;
  logic [31:0] blink_cnt_next;
  logic blink_reg;
  logic [NIN-1:0] in_prev_reg;
  logic [4:0] settle_cnt_reg;
  logic settled_reg;
  logic [NSRC-1:0] src_en_reg;
  logic [NSRC-1:0] sw_shut_reg;
  logic [`LSI_NIRQ-1:0] irq_stat_reg;
  logic [`LSI_NIRQ-1:0] irq_stat_next;
  logic [`LSI_NIRQ-1:0] irq_mask_reg;
  logic alarm_q_reg;
  logic ilk_q_reg;
  logic blank_q_reg;
  logic [31:0] prdata_reg;
  lsi_leds_t leds_reg;
  logic [NSRC-1:0] emit_en_reg;
  logic [NSRC-1:0] src_out_reg;
  logic [NSRC-1:0] shut_open_reg;

  // Bus decode
  wire logic wr_acc;
  wire logic rd_setup;
  wire logic hit_ctrl;
  wire logic hit_state;
  wire logic hit_stat;
  wire logic hit_mask;
  wire logic hit_any;
  wire logic [31:0] rd_mux;

  assign hit_ctrl = paddr == `LSI_OFS_CTRL;
  assign hit_state = paddr == `LSI_OFS_STATE;
  assign hit_stat = paddr == `LSI_OFS_IRQ_STAT;
  assign hit_mask = paddr == `LSI_OFS_IRQ_MASK;
  assign hit_any = hit_ctrl | hit_state | hit_stat | hit_mask;
  assign wr_acc = psel & penable & pwrite & hit_any;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_reg;

  wire logic [15:0] ctrl_val;
  wire logic [31:0] state_val;

  assign ctrl_val = 16'((32'(sw_shut_reg) << `LSI_CTRL_SHUT_LSB)
                        | (32'(src_en_reg) << `LSI_CTRL_EN_LSB));
  assign state_val = {9'h000, settled_reg, st_reg, 3'h0, panel,
                      unit_ready, 2'h0, 4'(src_alarm), 4'(src_stab)};
  assign rd_mux = hit_ctrl ? {16'h0000, ctrl_val} :
                  hit_state ? state_val :
                  hit_stat ? {27'h0000000, irq_stat_reg} :
                  hit_mask ? {27'h0000000, irq_mask_reg} :
                  32'h00000000;

  // Input stability after reset
  wire logic [NIN-1:0] in_vec;
  wire logic in_same;

  assign in_vec = {panel, unit_ready, src_alarm, src_stab,
                   mod_in, shut_cmd_in};
  assign in_same = in_vec == in_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev_reg <= '0;
      settle_cnt_reg <= 5'h00;
      settled_reg <= 1'b0;
    end else begin
      in_prev_reg <= in_vec;
      settle_cnt_reg <= in_same ? settle_cnt_reg + 5'h01 : 5'h00;
      if (in_same && settle_cnt_reg == 5'(`LSI_SETTLE_CYC - 1)) begin
        settled_reg <= 1'b1;
      end
    end
  end

  // Blink divider
  wire logic blink_wrap;

  assign blink_wrap = blink_cnt_reg == BLINK_HALF_CYC - 1;
  assign blink_cnt_next = blink_wrap ? 32'h00000000 : blink_cnt_reg + 32'h00000001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= 32'h00000000;
      blink_reg <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_cnt_next;
      if (blink_wrap) begin
        blink_reg <= ~blink_reg;
      end
    end
  end

  // Emission sequencing
  wire logic permit;
  wire logic start_ok;
  wire logic warn_done;

  assign permit = panel.key_on & panel.ilk_closed & settled_reg;
  assign start_ok = permit & unit_ready;
  assign warn_done = warn_cnt_reg == WARN_CYC - 1;

  always_comb begin
    st_next = st_reg;
    warn_cnt_next = 32'h00000000;
    unique case (st_reg)
      LSI_IDLE: begin
        if (start_ok) begin
          st_next = LSI_WARN;
        end
      end
      LSI_WARN: begin
        warn_cnt_next = warn_cnt_reg + 32'h00000001;
        if (!permit) begin
          st_next = LSI_IDLE;
        end else if (warn_done) begin
          st_next = LSI_EMIT;
        end
      end
      LSI_EMIT: begin
        if (!permit) begin
          st_next = LSI_IDLE;
        end
      end
      default: begin
        st_next = LSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= LSI_IDLE;
      warn_cnt_reg <= 32'h00000000;
    end else begin
      st_reg <= st_next;
      warn_cnt_reg <= warn_cnt_next;
    end
  end

  // Per-source outputs
  wire logic emitting;
  wire logic blank_c;
  wire logic alarm_c;
  wire logic [NSRC-1:0] en_c;
  wire logic [NSRC-1:0] out_c;
  wire logic [NSRC-1:0] shut_c;
  wire logic [NSRC-1:0] stab_ok;

  assign emitting = st_reg == LSI_EMIT && permit;
  assign blank_c = panel.blank_sw | panel.blank_sock;
  assign alarm_c = |src_alarm | ~panel.ilk_closed;

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    assign en_c[i] = emitting & src_en_reg[i];
    assign out_c[i] = en_c[i] & mod_in[i] & ~blank_c;
    assign shut_c[i] = settled_reg & panel.shut_sw_open
                       & (shut_cmd_in[i] | sw_shut_reg[i]);
    assign stab_ok[i] = src_stab[i] | ~en_c[i];
  end

  // Indicators
  lsi_leds_t leds_c;

  always_comb begin
    leds_c = '0;
    if (settled_reg) begin
      leds_c.status = ~|en_c ? 1'b0 :
                      &stab_ok ? 1'b1 :
                      blink_reg;
      leds_c.alarm = alarm_c;
      leds_c.emission = st_next == LSI_WARN ? blink_reg :
                        panel.key_on;
      leds_c.shutter = panel.shut_sw_open;
      leds_c.blank = blank_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds_reg <= '0;
      emit_en_reg <= '0;
      src_out_reg <= '0;
      shut_open_reg <= '0;
    end else begin
      leds_reg <= leds_c;
      emit_en_reg <= en_c;
      src_out_reg <= out_c;
      shut_open_reg <= shut_c;
    end
  end

  assign leds = leds_reg;
  assign emit_en = emit_en_reg;
  assign src_out_on = src_out_reg;
  assign shutter_open = shut_open_reg;

  // Interrupt events
  wire logic [`LSI_NIRQ-1:0] ev;
  wire logic [`LSI_NIRQ-1:0] w1c;

  assign ev[`LSI_IRQ_ALARM] = settled_reg & alarm_c & ~alarm_q_reg;
  assign ev[`LSI_IRQ_ILK] = settled_reg & ~panel.ilk_closed & ilk_q_reg;
  assign ev[`LSI_IRQ_WARN] = st_next == LSI_WARN && st_reg != LSI_WARN;
  assign ev[`LSI_IRQ_EMIT] = st_next == LSI_EMIT && st_reg != LSI_EMIT;
  assign ev[`LSI_IRQ_BLANK] = settled_reg & blank_c & ~blank_q_reg;
  assign w1c = (wr_acc & hit_stat) ? pwdata[`LSI_NIRQ-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~w1c) | ev;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_en_reg <= NSRC'(`LSI_CTRL_RST);
      sw_shut_reg <= NSRC'(`LSI_CTRL_RST);
      irq_mask_reg <= `LSI_MASK_RST;
      irq_stat_reg <= '0;
      alarm_q_reg <= 1'b0;
      ilk_q_reg <= 1'b1;
      blank_q_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      irq_stat_reg <= irq_stat_next;
      alarm_q_reg <= alarm_c;
      ilk_q_reg <= panel.ilk_closed;
      blank_q_reg <= blank_c;
      if (rd_setup) begin
        prdata_reg <= rd_mux;
      end
      if (wr_acc && hit_ctrl) begin
        src_en_reg <= pwdata[`LSI_CTRL_EN_LSB +: NSRC];
        sw_shut_reg <= pwdata[`LSI_CTRL_SHUT_LSB +: NSRC];
      end
      if (wr_acc && hit_mask) begin
        irq_mask_reg <= pwdata[`LSI_NIRQ-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_status_dark: assert property (
    !(|en_c) |=> !leds.status)
    else $error("status LED lit with no source enabled");

  chk_status_solid: assert property (
    (|en_c && &stab_ok && settled_reg) |=> leds.status)
    else $error("status LED not solid when all stabilized");

  chk_status_blink: assert property (
    (|en_c && !(&stab_ok)) |=> leds.status == $past(blink_reg))
    else $error("status LED not blinking during stabilization");

  chk_alarm_led: assert property (
    (settled_reg && (|src_alarm || !panel.ilk_closed)) |=> leds.alarm)
    else $error("alarm LED dark on alarm or open interlock");

  chk_ilk_cut: assert property (
    !panel.ilk_closed |=> emit_en == '0 && src_out_on == '0)
    else $error("emission with interlock open");

  chk_key_cut: assert property (
    !panel.key_on |=> emit_en == '0 && st_reg == LSI_IDLE)
    else $error("emission with key off");

  chk_warn_len: assert property (
    (st_reg == LSI_EMIT && $past(st_reg) == LSI_WARN)
    |-> $past(warn_cnt_reg) == WARN_CYC - 1)
    else $error("warning interval length wrong");

  chk_emit_state: assert property (
    |emit_en |-> $past(st_reg) == LSI_EMIT)
    else $error("emission outside emitting state");

  chk_shut_force: assert property (
    !panel.shut_sw_open |=> shutter_open == '0 && !leds.shutter)
    else $error("shutter open with switch closed");

  chk_blank_cut: assert property (
    (settled_reg && blank_c) |=> src_out_on == '0 && leds.blank)
    else $error("output present during blanking");

  chk_reset_hold: assert property (
    !settled_reg |=> leds == '0 && shutter_open == '0 && emit_en == '0)
    else $error("outputs active before inputs settled");

  chk_emis_steady: assert property (
    (settled_reg && st_next != LSI_WARN) |=> leds.emission == $past(panel.key_on))
    else $error("emission LED not following key");

  chk_warn_blink: assert property (
    (settled_reg && st_next == LSI_WARN) |=> leds.emission == $past(blink_reg))
    else $error("emission LED not blinking during warning");

  chk_warn_start: assert property (
    (st_reg == LSI_WARN && $past(st_reg) == LSI_IDLE) |-> warn_cnt_reg == 32'h00000000)
    else $error("warning counter not cleared at start");

  chk_shut_led: assert property (
    settled_reg |=> leds.shutter == $past(panel.shut_sw_open))
    else $error("shutter LED not following switch");

  chk_shut_cmd: assert property (
    (settled_reg && panel.shut_sw_open) |=> shutter_open == ($past(shut_cmd_in) | $past(sw_shut_reg)))
    else $error("shutter not following its commands");

  chk_mod_follow: assert property (
    (settled_reg && !blank_c) |=> src_out_on == ($past(en_c) & $past(mod_in)))
    else $error("output not following modulation input");

  chk_blink_step: assert property (
    $changed(blink_reg) |-> $past(blink_cnt_reg) == BLINK_HALF_CYC - 1)
    else $error("blink toggled off the divider wrap");

endmodule : lsi_ctrl

`default_nettype wire

// File: core/lsi_pkg.sv
// Types for the laser safety and indicator controller
`default_nettype none
package lsi_pkg;

  typedef enum logic [2:0] {
    LSI_IDLE = 3'h1,
    LSI_WARN = 3'h2,
    LSI_EMIT = 3'h4
  } lsi_state_t;

  typedef struct packed {
    logic key_on;
    logic ilk_closed;
    logic shut_sw_open;
    logic blank_sw;
    logic blank_sock;
  } lsi_panel_t;

  typedef struct packed {
    logic status;
    logic alarm;
    logic emission;
    logic shutter;
    logic blank;
  } lsi_leds_t;

endpackage : lsi_pkg

`default_nettype wire

// File: dv/lsi_ctrl_tb_top.sv
// Testbench for the laser safety and indicator controller
`timescale 1ns/1ps
`default_nettype none
module lsi_ctrl_tb_top import lsi_pkg::*;;
  localparam int WARN = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000BB66;
  logic pready, pslverr, irq, er, pe, unit_ready = 1'b1;
  lsi_panel_t panel = 5'h0C;
  lsi_leds_t leds;
  logic [1:0] src_alarm, src_stab, emit_en, src_out_on, shutter_open;
  logic [1:0] mod_in = 2'h0, shut_cmd_in = 2'h0, alarm_req = 2'h0;
  int n_errors = 0, n_tests = 0, n, tog, ones;
  int m_en = 0, m_shut = 0;

  lsi_ctrl #(.NSRC(2), .WARN_CYC(WARN), .BLINK_HALF_CYC(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .panel(panel), .unit_ready(unit_ready), .src_alarm(src_alarm),
    .src_stab(src_stab), .mod_in(mod_in), .shut_cmd_in(shut_cmd_in), .emit_en(emit_en),
    .src_out_on(src_out_on), .shutter_open(shutter_open), .leds(leds), .irq(irq));
  lsi_heads #(.STAB_CYC(12)) heads (.pclk(pclk), .presetn(presetn), .emit_en(emit_en),
    .src_stab(src_stab), .src_alarm(src_alarm), .alarm_req(alarm_req));

  initial begin
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Model of the shutter and output paths
  function automatic logic [31:0] m_shutter(input int cmd);
    return panel.shut_sw_open ? ((cmd | m_shut) & 3) : 0;
  endfunction : m_shutter

  function automatic logic [31:0] m_src(input int mod);
    return (panel.blank_sw || panel.blank_sock) ? 0 : (mod & m_en & 3);
  endfunction : m_src

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("Counts: tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic cy(input int k);
    repeat (k) @(posedge pclk);
  endtask : cy

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    if (w && a == 12'h000 && i < 50) begin
      m_en = d[1:0];
      m_shut = d[9:8];
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (i >= 50) begin
      n_errors++;
      finish_test();
    end
  endtask : apb

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  initial begin
    cy(3);
    presetn <= 1'b1;
    cy(8);
    chk(leds, 5'h00);
    chk(shutter_open, 2'h0);
    cy(20);
    chk(leds, 5'h02);
    $display("done: reset");
    apb(1'b1, 12'h000, 32'h303);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h303);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    chk(shutter_open, m_shutter(0));
    apb(1'b1, 12'h000, 32'h3);
    for (int k = 0; k < 4; k++) begin
      rd = rnd();
      shut_cmd_in <= rd[1:0];
      cy(3);
      chk(shutter_open, m_shutter(rd[1:0]));
    end
    panel.shut_sw_open <= 1'b0;
    shut_cmd_in <= 2'h3;
    cy(3);
    chk(shutter_open, 2'h0);
    chk(leds.shutter, 1'b0);
    panel.shut_sw_open <= 1'b1;
    apb(1'b1, 12'h00C, 32'h1F);
    apb(1'b1, 12'h008, 32'h1F);
    $display("done: shutter");
    panel.key_on <= 1'b1;
    n = 0;
    tog = 0;
    pe = 1'b0;
    while (emit_en === 2'h0 && n < 200) begin
      @(posedge pclk);
      n++;
      tog += (leds.emission !== pe);
      pe = leds.emission;
    end
    chk(n >= WARN && n <= WARN + 4, 1'b1);
    chk(tog >= 3, 1'b1);
    ones = 0;
    repeat (8) begin
      @(posedge pclk);
      ones += leds.status;
    end
    chk(ones > 0 && ones < 8, 1'b1);
    cy(16);
    chk(leds, 5'h16);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000000C);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h1F);
    chk(irq, 1'b0);
    $display("done: emission");
    for (int i = 0; i < 16; i++) begin
      rd = rnd();
      mod_in <= rd[1:0];
      panel.blank_sw <= (i == 3) || (i == 9);
      panel.blank_sock <= (i == 6) || (i == 9);
      cy(3);
      chk(src_out_on, m_src(mod_in));
      chk(leds.blank, panel.blank_sw | panel.blank_sock);
    end
    mod_in <= 2'h0;
    apb(1'b1, 12'h008, 32'h1F);
    chk(irq, 1'b0);
    $display("done: modulation");
    apb(1'b1, 12'h000, 32'h1);
    cy(2);
    chk(emit_en, m_en);
    alarm_req <= 2'h2;
    cy(3);
    chk(leds.alarm, 1'b1);
    chk(irq, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h00000001);
    alarm_req <= 2'h0;
    panel.ilk_closed <= 1'b0;
    cy(3);
    chk(emit_en, 2'h0);
    chk(leds.alarm, 1'b1);
    chk(leds.status, 1'b0);
    panel.ilk_closed <= 1'b1;
    unit_ready <= 1'b0;
    cy(40);
    chk(emit_en, 2'h0);
    unit_ready <= 1'b1;
    cy(30);
    chk(emit_en, 2'h1);
    panel.key_on <= 1'b0;
    cy(3);
    chk(emit_en, 2'h0);
    chk(leds.emission, 1'b0);
    $display("done: safety");
    finish_test();
  end
endmodule : lsi_ctrl_tb_top
`default_nettype wire

// File: dv/lsi_heads.sv
// Laser head model: stabilization delay and alarm levels
`timescale 1ns/1ps
`default_nettype none
module lsi_heads #(
  parameter int STAB_CYC = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device side
  input wire logic [1:0] emit_en,
  output logic [1:0] src_stab,
  output logic [1:0] src_alarm,
  // Bench control
  input wire logic [1:0] alarm_req
);
  int cnt [2];
  assign src_alarm = alarm_req;
  // Stabilized only after emitting for a while
  always @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 2; i++) begin
      if (!presetn || !emit_en[i]) begin
        cnt[i] <= 0;
        src_stab[i] <= 1'b0;
      end else begin
        if (cnt[i] < STAB_CYC) cnt[i] <= cnt[i] + 1;
        src_stab[i] <= (cnt[i] >= STAB_CYC - 1);
      end
    end
  end
endmodule : lsi_heads
`default_nettype wire
